// [pkg/scan_tile_pkg.sv]
// shared constants and types of the user scan tile bridge
// assumes a 10 MHz reference clock that samples the slower test port pins
package scan_tile_pkg;

	// sixteen controller states, encoded 0 to 15 in declaration order
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} tap_state_t;

	// widths
	localparam int IR_W = 8;
	localparam int DR_W = 32;

	// instruction codes kept outside the user range
	localparam logic [7:0] OP_EXTEST   = 8'h00;
	localparam logic [7:0] OP_SAMPLE   = 8'h01;
	localparam logic [7:0] OP_CLAMP    = 8'h05;
	localparam logic [7:0] OP_HIGHZ    = 8'h07;
	localparam logic [7:0] OP_USERCODE = 8'h0e;
	localparam logic [7:0] OP_IDCODE   = 8'h0f;
	localparam logic [7:0] OP_BYPASS   = 8'hff;

	// user range bounds, inclusive
	localparam logic [7:0] USER_LO = 8'h10;
	localparam logic [7:0] USER_HI = 8'h7f;

	// reset and capture values
	localparam logic [7:0]  IR_RESET_VAL   = 8'h0f;
	localparam logic [7:0]  IR_CAPTURE_VAL = 8'h01;
	localparam logic [31:0] DR_RESET_VAL   = 32'h0000_0000;

	// timing counts
	localparam int SYNC_STAGES     = 2;
	localparam int TMS_RESET_EDGES = 5;

endpackage

// [logic/scan_sync.sv]
// two flip-flop synchroniser for a bundle of independent pin levels
// assumes each bit is a slow level; bits are not coherent with each other
module scan_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// levels
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_t;

	sync_t q_reg;
	sync_t q_next;

	// first stage feeds only the second stage
	always_comb begin
		q_next        = q_reg;
		q_next.meta   = din;
		q_next.stable = q_reg.meta;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign dout = q_reg.stable;

endmodule

// [logic/user_scan_tile.sv]
// test port controller and user access tile on one reference clock
// assumes the test clock is far slower than REF_CLK (at least 8 samples a period)
//
// How it works
// - whole instruction register shown on instr_reg_view, eight bits.
// - codes 16 to 127 are user codes, core decodes them freely.
// - instr_reg_view changes only on entry to Update-IR or in Test-Logic-Reset.
// - tap_reset_n low whenever in Test-Logic-Reset, also from power-up.
// - user_serial_in and user_test_clock wired straight from the pins.
// - in user range, user_serial_out drives the test data output in Shift-DR.
// - shift, update, capture flags high exactly in their DR states.
// - sixteen-state controller stepped by mode-select at rising test clock.
// - power-up and test reset pin force Test-Logic-Reset.
// - out of reset, state moves only on rising test clock edges.
// - serial input carries DR bits in Shift-DR, IR bits in Shift-IR.
// - IR works only in IR states, data register only in DR states.
// - tile stays connected in normal operation, no test mode needed.
// - standard codes, identification 0F and bypass FF, stay outside user range.
module user_scan_tile #(
	parameter logic [31:0] ID_VALUE   = 32'h0000_1001, // arbitrary value
	parameter logic [31:0] USER_VALUE = 32'h0000_0000  // arbitrary value
) (
	// clock and reset
	input  wire logic       REF_CLK,
	input  wire logic       RST,
	// test port pins
	input  wire logic       TCK,
	input  wire logic       TMS,
	input  wire logic       TDI,
	input  wire logic       TRST_N,
	output logic            TDO_O,
	output logic            TDO_OE,
	// core side
	output logic [7:0]      INSTR_REG_VIEW,
	output logic            TAP_RESET_N,
	output logic            USER_SERIAL_IN,
	output logic            USER_TEST_CLOCK,
	input  wire logic       USER_SERIAL_OUT,
	output logic            DR_SHIFT_FLAG,
	output logic            DR_UPDATE_FLAG,
	output logic            DR_CAPTURE_FLAG
);

	// saturation point of the mode-select run counter; it only has to reach the reset count
	localparam logic [2:0] ONES_MAX = 3'(scan_tile_pkg::TMS_RESET_EDGES);

	typedef struct packed {
		scan_tile_pkg::tap_state_t st;
		logic [7:0]                ir_sh;
		logic [7:0]                ir;
		logic [31:0]               dr;
		logic                      tck_q;
		logic                      tdo;
		logic                      tdo_en;
		logic                      rst_n;
		logic                      shf;
		logic                      upd;
		logic                      cap;
		logic [2:0]                ones;
	} core_t;

	core_t      q_reg;
	core_t      q_next;
	logic [4:0] pins;
	logic       s_tck;
	logic       s_tms;
	logic       s_tdi;
	logic       s_trst_n;
	logic       s_uso;
	logic       rise;
	logic       fall;
	logic       user_range;
	logic       wide_dr;

	// user_serial_out comes from core logic on the test clock, so it is resampled too
	scan_sync #(.WIDTH(5)) u_sync (
		.clk  (REF_CLK),
		.rst  (RST),
		.din  ({TRST_N, USER_SERIAL_OUT, TDI, TMS, TCK}),
		.dout (pins)
	);
	assign {s_trst_n, s_uso, s_tdi, s_tms, s_tck} = pins;

	// edges of the sampled test clock; all sampled pins share the same delay
	assign rise = s_tck & ~q_reg.tck_q;
	assign fall = ~s_tck & q_reg.tck_q;

	assign user_range = (q_reg.ir >= scan_tile_pkg::USER_LO) && (q_reg.ir <= scan_tile_pkg::USER_HI);
	assign wide_dr    = (q_reg.ir == scan_tile_pkg::OP_IDCODE) || (q_reg.ir == scan_tile_pkg::OP_USERCODE);

	// standard controller transitions
	function automatic scan_tile_pkg::tap_state_t tap_step(input scan_tile_pkg::tap_state_t s, input logic m);
		scan_tile_pkg::tap_state_t r;
		r = s;
		case (s)
			scan_tile_pkg::TLR:    r = m ? scan_tile_pkg::TLR    : scan_tile_pkg::RTI;
			scan_tile_pkg::RTI:    r = m ? scan_tile_pkg::SEL_DR : scan_tile_pkg::RTI;
			scan_tile_pkg::SEL_DR: r = m ? scan_tile_pkg::SEL_IR : scan_tile_pkg::CAP_DR;
			scan_tile_pkg::CAP_DR: r = m ? scan_tile_pkg::EX1_DR : scan_tile_pkg::SHF_DR;
			scan_tile_pkg::SHF_DR: r = m ? scan_tile_pkg::EX1_DR : scan_tile_pkg::SHF_DR;
			scan_tile_pkg::EX1_DR: r = m ? scan_tile_pkg::UPD_DR : scan_tile_pkg::PAU_DR;
			scan_tile_pkg::PAU_DR: r = m ? scan_tile_pkg::EX2_DR : scan_tile_pkg::PAU_DR;
			scan_tile_pkg::EX2_DR: r = m ? scan_tile_pkg::UPD_DR : scan_tile_pkg::SHF_DR;
			scan_tile_pkg::UPD_DR: r = m ? scan_tile_pkg::SEL_DR : scan_tile_pkg::RTI;
			scan_tile_pkg::SEL_IR: r = m ? scan_tile_pkg::TLR    : scan_tile_pkg::CAP_IR;
			scan_tile_pkg::CAP_IR: r = m ? scan_tile_pkg::EX1_IR : scan_tile_pkg::SHF_IR;
			scan_tile_pkg::SHF_IR: r = m ? scan_tile_pkg::EX1_IR : scan_tile_pkg::SHF_IR;
			scan_tile_pkg::EX1_IR: r = m ? scan_tile_pkg::UPD_IR : scan_tile_pkg::PAU_IR;
			scan_tile_pkg::PAU_IR: r = m ? scan_tile_pkg::EX2_IR : scan_tile_pkg::PAU_IR;
			scan_tile_pkg::EX2_IR: r = m ? scan_tile_pkg::UPD_IR : scan_tile_pkg::SHF_IR;
			scan_tile_pkg::UPD_IR: r = m ? scan_tile_pkg::SEL_DR : scan_tile_pkg::RTI;
			default:               r = scan_tile_pkg::TLR;
		endcase
		return r;
	endfunction

	// controller, registers and output stage
	always_comb begin
		q_next       = q_reg;
		q_next.tck_q = s_tck;
		if (!s_trst_n) begin
			q_next.st = scan_tile_pkg::TLR;
		end else if (rise) begin
			q_next.st = tap_step(q_reg.st, s_tms);
		end
		// run of rising edges with mode-select high, saturating so it never wraps back below the reset count
		if (rise) begin
			q_next.ones = !s_tms ? 3'h0 : ((q_reg.ones == ONES_MAX) ? ONES_MAX : q_reg.ones + 3'h1);
		end
		// register actions happen only in their own path states
		if (rise && s_trst_n) begin
			case (q_reg.st)
				scan_tile_pkg::CAP_IR: q_next.ir_sh = scan_tile_pkg::IR_CAPTURE_VAL;
				scan_tile_pkg::SHF_IR: q_next.ir_sh = {s_tdi, q_reg.ir_sh[7:1]};
				scan_tile_pkg::CAP_DR: q_next.dr = (q_reg.ir == scan_tile_pkg::OP_IDCODE) ? ID_VALUE :
					(q_reg.ir == scan_tile_pkg::OP_USERCODE) ? USER_VALUE : scan_tile_pkg::DR_RESET_VAL;
				scan_tile_pkg::SHF_DR: q_next.dr = wide_dr ? {s_tdi, q_reg.dr[31:1]} : {31'h0, s_tdi};
				default: q_next.dr = q_reg.dr;
			endcase
		end
		// the view only moves on entry to Update-IR, or back to the reset code in reset
		if (q_next.st == scan_tile_pkg::UPD_IR && q_reg.st != scan_tile_pkg::UPD_IR) begin
			q_next.ir = q_reg.ir_sh;
		end else if (q_next.st == scan_tile_pkg::TLR) begin
			q_next.ir = scan_tile_pkg::IR_RESET_VAL;
		end
		// output launched on the falling edge so the tester samples it on the next rise
		if (fall && q_reg.st == scan_tile_pkg::SHF_IR) begin
			q_next.tdo    = q_reg.ir_sh[0];
			q_next.tdo_en = 1'b1;
		end else if (fall && q_reg.st == scan_tile_pkg::SHF_DR) begin
			q_next.tdo    = user_range ? s_uso : q_reg.dr[0];
			q_next.tdo_en = 1'b1;
		end
		// drop the enable as soon as shifting ends, not half a test clock later
		if (q_next.st != scan_tile_pkg::SHF_IR && q_next.st != scan_tile_pkg::SHF_DR) begin
			q_next.tdo_en = 1'b0;
		end
		// flags follow the state register exactly
		q_next.rst_n = (q_next.st != scan_tile_pkg::TLR);
		q_next.shf   = (q_next.st == scan_tile_pkg::SHF_DR);
		q_next.upd   = (q_next.st == scan_tile_pkg::UPD_DR);
		q_next.cap   = (q_next.st == scan_tile_pkg::CAP_DR);
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			q_reg       <= '0;
			q_reg.st    <= scan_tile_pkg::TLR;
			q_reg.ir    <= scan_tile_pkg::IR_RESET_VAL;
			q_reg.ir_sh <= scan_tile_pkg::IR_RESET_VAL;
		end else begin
			q_reg <= q_next;
		end
	end

	// outputs; the tile is always attached, no test mode gate
	assign INSTR_REG_VIEW  = q_reg.ir;
	assign TAP_RESET_N     = q_reg.rst_n;
	assign DR_SHIFT_FLAG   = q_reg.shf;
	assign DR_UPDATE_FLAG  = q_reg.upd;
	assign DR_CAPTURE_FLAG = q_reg.cap;
	assign TDO_O           = q_reg.tdo;
	assign TDO_OE          = q_reg.tdo_en;
	// straight wires, so the core sees the pin without added delay
	assign USER_SERIAL_IN  = TDI;
	assign USER_TEST_CLOCK = TCK;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	a_view_moves_update: assert property (!$stable(INSTR_REG_VIEW) && q_reg.st != scan_tile_pkg::TLR
		|-> q_reg.st == scan_tile_pkg::UPD_IR && $past(q_reg.st) != scan_tile_pkg::UPD_IR)
		else $error("instruction view changed outside Update-IR entry");
	a_reset_flag_low: assert property (TAP_RESET_N == (q_reg.st != scan_tile_pkg::TLR))
		else $error("reset flag disagrees with state");
	a_shift_flag_state: assert property (DR_SHIFT_FLAG == (q_reg.st == scan_tile_pkg::SHF_DR))
		else $error("shift flag wrong");
	a_update_capture_flags: assert property ((DR_UPDATE_FLAG == (q_reg.st == scan_tile_pkg::UPD_DR))
		&& (DR_CAPTURE_FLAG == (q_reg.st == scan_tile_pkg::CAP_DR)))
		else $error("update or capture flag wrong");
	a_trst_forces_reset: assert property (!s_trst_n |=> q_reg.st == scan_tile_pkg::TLR && !TAP_RESET_N)
		else $error("test reset pin did not reset controller");
	a_state_on_rise: assert property (!$stable(q_reg.st) |-> $past(rise) || !$past(s_trst_n))
		else $error("state moved without rising test clock");
	a_five_ones_reset: assert property (q_reg.ones == ONES_MAX |-> q_reg.st == scan_tile_pkg::TLR)
		else $error("five high mode-select edges did not reset");
	a_user_output_route: assert property (fall && s_trst_n && q_reg.st == scan_tile_pkg::SHF_DR && user_range
		|=> TDO_O == $past(s_uso) && TDO_OE)
		else $error("user output not routed");
	a_own_output_route: assert property (fall && q_reg.st == scan_tile_pkg::SHF_DR && !user_range
		|=> TDO_O == $past(q_reg.dr[0]))
		else $error("own register not routed");
	a_enable_shift_only: assert property (TDO_OE |-> q_reg.st == scan_tile_pkg::SHF_DR
		|| q_reg.st == scan_tile_pkg::SHF_IR)
		else $error("output enabled outside shift states");
	a_pin_passthrough: assert property (USER_SERIAL_IN == TDI && USER_TEST_CLOCK == TCK)
		else $error("pass-through broken");

endmodule

// [sim/scan_tester.sv]
// far side model: an external tester driving the test port pins
// assumes a 100 ns clk; each test clock half lasts four clk cycles
module scan_tester (
	// clock
	input  wire logic clk,
	// test port pins
	input  wire logic tdo_o,
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	output logic      trst_n
);
	timeunit 1ns;
	timeprecision 1ns;

	// pins idle with mode-select high so the controller sits in reset
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trst_n = 1'b1;
	end

	// one test clock period, entered at a clk edge; data changes with the fall
	task automatic step(input logic m, input logic d, output logic q);
		tck <= 1'b0;
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge clk);
		q = tdo_o; // settled three edges after the fall
		tck <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	// test reset pin held long enough to pass the pin synchroniser
	task automatic pulse_trst();
		trst_n <= 1'b0;
		repeat (6) @(posedge clk);
		trst_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
endmodule

// [sim/user_jtag_core_bridge_tb.sv]
// self-checking bench for the user scan tile
// assumes the tester model steps the link; the bench plays the core logic
module user_jtag_core_bridge_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] ID_EXP   = 32'h0000_1001; // arbitrary value
	localparam logic [31:0] USER_EXP = 32'h0000_0a5c; // arbitrary value
	logic       ref_clk, rst, tck, tms, tdi, trst_n, tdo_o, tdo_oe;
	logic       rst_n_v, usi, utc, usr_out, sh, up, cap;
	logic [7:0] view;
	int         mismatches, checked;

	user_scan_tile #(.ID_VALUE(ID_EXP), .USER_VALUE(USER_EXP)) DUT (
		.REF_CLK         (ref_clk),
		.RST             (rst),
		.TCK             (tck),
		.TMS             (tms),
		.TDI             (tdi),
		.TRST_N          (trst_n),
		.TDO_O           (tdo_o),
		.TDO_OE          (tdo_oe),
		.INSTR_REG_VIEW  (view),
		.TAP_RESET_N     (rst_n_v),
		.USER_SERIAL_IN  (usi),
		.USER_TEST_CLOCK (utc),
		.USER_SERIAL_OUT (usr_out),
		.DR_SHIFT_FLAG   (sh),
		.DR_UPDATE_FLAG  (up),
		.DR_CAPTURE_FLAG (cap)
	);

	scan_tester u_tst (.clk(ref_clk), .tdo_o(tdo_o), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));

	// 10 MHz reference clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one full scan from idle back to idle; flags judged in Capture, Shift, Exit1, Update and Idle, not in the Select states
	task automatic scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
		logic       q;
		logic [7:0] old;
		old = view;
		dout = 32'h0;
		u_tst.step(1'b1, 1'b0, q);
		if (ir) u_tst.step(1'b1, 1'b0, q);
		u_tst.step(1'b0, 1'b0, q);
		check("cap flags", {2'b00, !ir}, {sh, up, cap});
		u_tst.step(1'b0, 1'b0, q);
		check("shift flags", {!ir, 2'b00}, {sh, up, cap});
		for (int i = 0; i < n; i++) begin
			u_tst.step(i == n - 1, din[i], q);
			dout[i] = q;
			check("stream valid", !ir && (i < n - 1), sh);
			if (i == 0 && n > 1) check("shift enable", 1'b1, tdo_oe);
		end
		check("exit enable", 1'b0, tdo_oe);
		check("view held", old, view);
		u_tst.step(1'b1, 1'b0, q);
		check("upd flags", {1'b0, !ir, 1'b0}, {sh, up, cap});
		if (ir) check("view", din[7:0], view);
		u_tst.step(1'b0, 1'b0, q);
		check("idle flags", 3'b000, {sh, up, cap});
	endtask

	// load an instruction, then shift a data register with the core output held
	task automatic run(input logic [7:0] code, input logic uo, input logic [31:0] din, input int n,
		input logic [31:0] exp);
		logic [31:0] d;
		scan(1'b1, {24'h0, code}, 8, d);
		check("ir capture", scan_tile_pkg::IR_CAPTURE_VAL, d[7:0]);
		usr_out <= uo;
		scan(1'b0, din, n, d);
		check("dr out", exp, d);
	endtask

	task automatic t_reset();
		logic q;
		check("reset view", scan_tile_pkg::IR_RESET_VAL, view);
		check("reset low", 1'b0, rst_n_v);
		check("reset flags", 4'h0, {sh, up, cap, tdo_oe});
		check("pass low", 2'b00, {utc, usi});
		u_tst.step(1'b0, 1'b1, q);
		check("pass high", 2'b11, {utc, usi});
		check("left reset", 1'b1, rst_n_v);
	endtask

	// five mode-select highs from Shift-DR; the fourth must not yet reach reset
	task automatic t_tms_reset();
		logic q;
		u_tst.step(1'b1, 1'b0, q);
		u_tst.step(1'b0, 1'b0, q);
		u_tst.step(1'b0, 1'b0, q);
		repeat (4) u_tst.step(1'b1, 1'b0, q);
		check("four highs", 1'b1, rst_n_v);
		u_tst.step(1'b1, 1'b0, q);
		check("five highs", 1'b0, rst_n_v);
		check("tms view", scan_tile_pkg::IR_RESET_VAL, view);
		u_tst.step(1'b0, 1'b0, q);
	endtask

	// split instruction load through Pause-IR and Exit2-IR, then a data scan parked in Pause-DR
	task automatic t_pause();
		logic       q;
		logic [7:0] c;
		logic [7:0] old;
		c = 8'h3a;
		old = view;
		usr_out <= 1'b1;
		u_tst.step(1'b1, 1'b0, q);
		u_tst.step(1'b1, 1'b0, q);
		u_tst.step(1'b0, 1'b0, q);
		u_tst.step(1'b0, 1'b0, q);
		for (int i = 0; i < 4; i++) begin
			u_tst.step(i == 3, c[i], q);
		end
		u_tst.step(1'b0, 1'b0, q);
		check("ir pause", 4'h0, {sh, up, cap, tdo_oe});
		check("pause view", old, view);
		u_tst.step(1'b1, 1'b0, q);
		u_tst.step(1'b0, 1'b0, q);
		for (int i = 4; i < 8; i++) begin
			u_tst.step(i == 7, c[i], q);
		end
		u_tst.step(1'b1, 1'b0, q);
		check("split view", c, view);
		u_tst.step(1'b1, 1'b0, q);
		u_tst.step(1'b0, 1'b0, q);
		u_tst.step(1'b0, 1'b0, q);
		u_tst.step(1'b1, 1'b0, q);
		check("paused bit", 1'b1, q);
		u_tst.step(1'b0, 1'b0, q);
		check("dr pause", 4'h0, {sh, up, cap, tdo_oe});
		u_tst.step(1'b1, 1'b0, q);
		u_tst.step(1'b1, 1'b0, q);
		check("pause upd", 3'b010, {sh, up, cap});
		u_tst.step(1'b0, 1'b0, q);
		check("pause idle", 3'b000, {sh, up, cap});
	endtask

	task automatic t_trst();
		logic [31:0] d;
		logic        q;
		scan(1'b1, 32'h20, 8, d);
		u_tst.pulse_trst();
		check("trst low", 1'b0, rst_n_v);
		check("trst view", scan_tile_pkg::IR_RESET_VAL, view);
		u_tst.step(1'b0, 1'b0, q);
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// watchdog well beyond the few thousand cycles the scans need
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		finish_test();
	end

	// main sequence
	initial begin
		rst = 1'b1;
		usr_out = 1'b0;
		mismatches = 0;
		checked = 0;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (5) @(posedge ref_clk);
		t_reset();
		run(8'h10, 1'b1, 32'h0, 8, 32'hff);
		run(8'h7f, 1'b0, 32'hff, 8, 32'h0);
		run(8'h80, 1'b1, 32'h5, 4, 32'ha);
		run(scan_tile_pkg::OP_BYPASS, 1'b1, 32'h5, 4, 32'ha);
		run(scan_tile_pkg::OP_EXTEST, 1'b1, 32'h5, 4, 32'ha);
		run(scan_tile_pkg::OP_SAMPLE, 1'b1, 32'h5, 4, 32'ha);
		run(scan_tile_pkg::OP_CLAMP, 1'b1, 32'h5, 4, 32'ha);
		run(scan_tile_pkg::OP_HIGHZ, 1'b1, 32'h5, 4, 32'ha);
		run(scan_tile_pkg::OP_IDCODE, 1'b1, 32'h0, 32, ID_EXP);
		run(scan_tile_pkg::OP_USERCODE, 1'b1, 32'h0, 32, USER_EXP);
		t_tms_reset();
		t_pause();
		t_trst();
		finish_test();
	end
endmodule
